// file: design/crp_pkg.sv
// Package: constants for the clock, reset and interrupt pin logic
package crp_pkg;
  localparam int unsigned OSC_DIV = 4;
  localparam logic [1:0] PHASE_RST = 2'h0;
  localparam logic [1:0] PHASE_HIGH_START = 2'h2;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam int unsigned EXT_CLASS_CYCLES = 2;
  localparam int unsigned RST_SAMPLE_OSC = EXT_CLASS_CYCLES * OSC_DIV;
  localparam logic [3:0] RST_CNT_RST = 4'h0;
  localparam logic [1:0] SYNC_IDLE = 2'h3;
  localparam logic IRQ_PREV_RST = 1'h1;
  localparam logic ECLK_RST = 1'h0;
  localparam logic DRIVE_RST = 1'h0;
  localparam logic EDGE_LATCH_RST = 1'h0;
  localparam logic IRQ_EDGE_RST = 1'h0;
  localparam logic EXT_CLASS_RST = 1'h0;
endpackage

// file: design/crp_clock_reset_irq.sv
// Pin logic: bus phase clock divider, reset pin handling and interrupt input
`timescale 1ns/1ns
`default_nettype none
module crp_clock_reset_irq (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_reset_pin_in,
  input wire logic i_clk_mon_fail,
  input wire logic i_operating_watchdog_fail,
  input wire logic i_halt,
  input wire logic i_single_chip,
  input wire logic i_eclk_off,
  input wire logic i_irq_n,
  input wire logic i_irq_edge_sel,
  input wire logic i_irq_ack,
  output logic o_reset_pin_out,
  output logic o_reset_pin_oe,
  output logic o_sys_rst_n,
  output logic o_reset_external,
  output logic o_eclk,
  output logic o_eclk_tick,
  output logic o_data_phase,
  output logic o_irq_req
);
  // Oscillator input is i_mclk; reset pin and irq are asynchronous pins
  localparam logic [3:0] RISE_LAST = 4'(crp_pkg::RST_SAMPLE_OSC - 1);

  logic [1:0] rpin_sync_reg, rpin_sync_next;
  logic [1:0] irq_sync_reg, irq_sync_next;
  logic irq_prev_reg, irq_prev_next;
  logic [1:0] phase_reg, phase_next;
  logic eclk_reg, eclk_next;
  logic [3:0] rcnt_reg, rcnt_next;
  logic ext_reg, ext_next;
  logic edge_sel_reg, edge_sel_next;
  logic edge_latch_reg, edge_latch_next;
  logic drive_reg, drive_next;
  logic pin_low;
  logic irq_low;
  logic fall;

  typedef enum logic [2:0] {
    CRP_RUN = 3'h1,
    CRP_HOLD = 3'h2,
    CRP_SAMPLE = 3'h4
  } crp_state_t;
  crp_state_t st_reg, st_next;

  // Every state but run counts as reset
  function automatic logic is_running(input crp_state_t st);
    return (st == CRP_RUN);
  endfunction

  assign pin_low = ~rpin_sync_reg[1];
  assign irq_low = ~irq_sync_reg[1];
  assign fall = irq_prev_reg & irq_low;

  // Pin synchronisers: logic reads only the second flop
  always_comb begin
    rpin_sync_next = {rpin_sync_reg[0], i_reset_pin_in};
    irq_sync_next = {irq_sync_reg[0], i_irq_n};
    irq_prev_next = irq_sync_reg[1];
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // Idle-high start, so no false falling edge follows reset
      rpin_sync_reg <= crp_pkg::SYNC_IDLE;
      irq_sync_reg <= crp_pkg::SYNC_IDLE;
      irq_prev_reg <= crp_pkg::IRQ_PREV_RST;
    end else begin
      rpin_sync_reg <= rpin_sync_next;
      irq_sync_reg <= irq_sync_next;
      irq_prev_reg <= irq_prev_next;
    end
  end

  // Divider: phases 0 and 1 internal work, 2 and 3 data access
  always_comb begin
    // Halt freezes the divider so the bus phase clock stops
    if (i_halt) begin
      phase_next = phase_reg;
    end else begin
      phase_next = 2'(phase_reg + 2'h1);
    end
    eclk_next = (phase_next >= crp_pkg::PHASE_HIGH_START);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_reg <= crp_pkg::PHASE_RST;
      eclk_reg <= crp_pkg::ECLK_RST;
    end else begin
      phase_reg <= phase_next;
      eclk_reg <= eclk_next;
    end
  end

  // Reset pin: open-drain pull, hold while low, then classify the rise
  always_comb begin
    // Failure pulls the pin until the failure goes away
    drive_next = i_clk_mon_fail | i_operating_watchdog_fail;
    st_next = st_reg;
    rcnt_next = rcnt_reg;
    ext_next = ext_reg;
    case (st_reg)
      CRP_RUN: begin
        if (pin_low) begin
          st_next = CRP_HOLD;
          rcnt_next = crp_pkg::RST_CNT_RST;
          ext_next = crp_pkg::EXT_CLASS_RST;
        end
      end
      CRP_HOLD: begin
        if (drive_reg) begin
          // Rise time counts only from the release of our own driver
          rcnt_next = crp_pkg::RST_CNT_RST;
          ext_next = crp_pkg::EXT_CLASS_RST;
        end else if (pin_low) begin
          // Low for two bus cycles: held outside, or a slow RC rise
          if (rcnt_reg == RISE_LAST) begin
            ext_next = 1'h1;
          end else begin
            rcnt_next = 4'(rcnt_reg + 4'h1);
          end
        end
        if (!pin_low) begin
          st_next = CRP_SAMPLE;
        end
      end
      CRP_SAMPLE: begin
        // Dropping again right after the rise means an outside hold
        if (pin_low) begin
          ext_next = 1'h1;
          st_next = CRP_HOLD;
        end else begin
          st_next = CRP_RUN;
        end
      end
      default: begin
        // Illegal code goes through a full reset
        st_next = CRP_HOLD;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rcnt_reg <= crp_pkg::RST_CNT_RST;
      ext_reg <= crp_pkg::EXT_CLASS_RST;
      drive_reg <= crp_pkg::DRIVE_RST;
      st_reg <= CRP_HOLD;
    end else begin
      rcnt_reg <= rcnt_next;
      ext_reg <= ext_next;
      drive_reg <= drive_next;
      st_reg <= st_next;
    end
  end

  // Interrupt input: option bit honoured only in the run state
  always_comb begin
    edge_sel_next = crp_pkg::IRQ_EDGE_RST;
    edge_latch_next = crp_pkg::EDGE_LATCH_RST;
    if (is_running(st_reg)) begin
      edge_sel_next = i_irq_edge_sel;
      edge_latch_next = edge_latch_reg;
      if (edge_sel_reg && fall) begin
        // A new edge wins over an acknowledge in the same cycle
        edge_latch_next = 1'h1;
      end else if (i_irq_ack) begin
        edge_latch_next = 1'h0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      edge_sel_reg <= crp_pkg::IRQ_EDGE_RST;
      edge_latch_reg <= crp_pkg::EDGE_LATCH_RST;
    end else begin
      edge_sel_reg <= edge_sel_next;
      edge_latch_reg <= edge_latch_next;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign o_reset_pin_out = 1'h0;
  assign o_reset_pin_oe = drive_reg;
  assign o_sys_rst_n = is_running(st_reg);
  assign o_reset_external = ext_reg;
  // Gate only allowed in single-chip modes
  assign o_eclk = eclk_reg & ~(i_single_chip & i_eclk_off);
  assign o_eclk_tick = ~i_halt & (phase_reg == crp_pkg::PHASE_LAST);
  assign o_data_phase = eclk_reg;
  // Level mode keeps requesting while any wired-OR source holds the line
  assign o_irq_req = is_running(st_reg) & (edge_sel_reg ? edge_latch_reg : irq_low);

  a_eclk_div: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !i_halt && $rose(eclk_reg) ##1 !i_halt |-> eclk_reg ##1 !eclk_reg)
    else $error("bus phase clock not divided by four");
  a_halt_freeze: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_halt |=> $stable(phase_reg))
    else $error("divider advanced during halt");
  a_od_drive: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_reset_pin_oe |-> !o_reset_pin_out)
    else $error("reset pin driven high");
  a_fail_pull: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_clk_mon_fail || i_operating_watchdog_fail |=> o_reset_pin_oe)
    else $error("failure did not pull reset pin");
  a_pin_reset: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !rpin_sync_reg[1] |=> !o_sys_rst_n)
    else $error("low reset pin did not reset logic");
  a_ext_class: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    st_reg == CRP_HOLD && !drive_reg && pin_low && rcnt_reg == RISE_LAST |=> ext_reg)
    else $error("slow reset rise not classed external");
  a_lvl_default: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    st_reg == CRP_HOLD |=> !edge_sel_reg)
    else $error("edge mode survived reset");
  a_edge_seen: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    is_running(st_reg) && edge_sel_reg && fall |=> edge_latch_reg)
    else $error("falling edge lost");
  a_sync_delay: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $fell(i_irq_n) ##1 !i_irq_n |=> irq_low)
    else $error("irq synchroniser depth wrong");
  a_eclk_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_single_chip && i_eclk_off |-> !o_eclk)
    else $error("bus clock output not gated");

  c_ext_reset: cover property (@(posedge i_mclk) disable iff (!i_rst_n) $rose(ext_reg));
  c_edge_irq: cover property (@(posedge i_mclk) disable iff (!i_rst_n) edge_sel_reg && $rose(o_irq_req));
  c_halt: cover property (@(posedge i_mclk) disable iff (!i_rst_n) i_halt [*3]);
  c_int_reset: cover property (@(posedge i_mclk) disable iff (!i_rst_n) $rose(o_reset_pin_oe));
  c_level_irq: cover property (@(posedge i_mclk) disable iff (!i_rst_n) !edge_sel_reg && $rose(o_irq_req));
endmodule // crp_clock_reset_irq
`default_nettype wire

// file: tb/crp_board_model.sv
// Board side: reset circuitry and wired-OR interrupt sources
`timescale 1ns/1ns
`default_nettype none
module crp_board_model (
  input wire logic i_ext_rst,
  input wire logic i_pin_out,
  input wire logic i_pin_oe,
  input wire logic [1:0] i_src_low,
  output logic o_reset_pin,
  output logic o_irq_n
);
  // Pull-up with no RC delay, so the pin rises at once
  assign o_reset_pin = !(i_ext_rst || (i_pin_oe && !i_pin_out));
  // Sources hold the line low while their i_src_low bit is set
  assign o_irq_n = !(|i_src_low);
endmodule // crp_board_model
`default_nettype wire

// file: tb/crp_clock_reset_irq_tb.sv
// Testbench for the clock, reset and interrupt pin logic
`timescale 1ns/1ns
`default_nettype none
module crp_clock_reset_irq_tb;
  logic i_mclk = 0, i_rst_n = 0, ext = 0, cmf = 0, wdf = 0, halt = 0, sc = 0, off = 0, esel = 0, ack = 0;
  logic [1:0] src = 2'h0;
  logic pin, irq_n, p_out, p_oe, srst_n, rext, eclk, tick, data_ph, irq_req, v;
  int errors = 0, checks = 0, cyc = 0, i;
  crp_clock_reset_irq u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_reset_pin_in(pin),
    .i_clk_mon_fail(cmf), .i_operating_watchdog_fail(wdf), .i_halt(halt), .i_single_chip(sc),
    .i_eclk_off(off), .i_irq_n(irq_n), .i_irq_edge_sel(esel), .i_irq_ack(ack),
    .o_reset_pin_out(p_out), .o_reset_pin_oe(p_oe), .o_sys_rst_n(srst_n), .o_reset_external(rext),
    .o_eclk(eclk), .o_eclk_tick(tick), .o_data_phase(data_ph), .o_irq_req(irq_req));
  crp_board_model u_board (.i_ext_rst(ext), .i_pin_out(p_out), .i_pin_oe(p_oe), .i_src_low(src),
    .o_reset_pin(pin), .o_irq_n(irq_n));
  initial forever #20 i_mclk = !i_mclk;
  task automatic wt(input int n);
    repeat (n) @(posedge i_mclk);
    #2;
  endtask
  task automatic chk(input string name, input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    // Whole run needs well under a thousand cycles
    if (cyc == 3000) begin
      errors++;
      end_sim();
    end
  end
  task automatic t_divider;
    for (i = 0; i < 8 && eclk !== 1'b0; i++) wt(1);
    for (i = 0; i < 8 && eclk !== 1'b1; i++) wt(1);
    for (i = 0; i < 8; i++) begin
      chk("eclk", eclk, (i % 4) < 2);
      chk("data_phase", data_ph, (i % 4) < 2);
      chk("eclk_tick", tick, (i % 4) == 1);
      wt(1);
    end
  endtask
  task automatic t_halt_gate;
    halt = 1;
    wt(1);
    v = eclk;
    // Checked every cycle: a running divider repeats after four
    for (i = 0; i < 6; i++) begin
      wt(1);
      chk("eclk_halted", eclk, v);
      chk("tick_halted", tick, 1'h0);
    end
    halt = 0;
    off = 1;
    v = 1'h0;
    for (i = 0; i < 4; i++) begin
      wt(1);
      v = v | eclk;
    end
    chk("eclk_not_gated", v, 1'h1);
    sc = 1;
    for (i = 0; i < 6; i++) begin
      wt(1);
      chk("eclk_gated", eclk, 1'b0);
    end
    off = 0;
    sc = 0;
  endtask
  task automatic t_reset(input logic from_wd, input logic exp_ext);
    if (from_wd) wdf = 1;
    else ext = 1;
    wt(2);
    chk("pin_oe", p_oe, from_wd);
    chk("pin_out", p_out, 1'b0);
    wt(10);
    chk("sys_rst_n", srst_n, 1'b0);
    src = 2'h1;
    wt(4);
    chk("irq_in_reset", irq_req, 1'b0);
    src = 2'h0;
    wdf = 0;
    ext = 0;
    wt(30);
    chk("sys_rst_n_up", srst_n, 1'b1);
    chk("reset_external", rext, exp_ext);
  endtask
  task automatic t_irq(input logic edge_mode);
    esel = edge_mode;
    src = 2'h3;
    wt(4);
    chk("irq_req", irq_req, 1'b1);
    src = 2'h2;
    wt(4);
    chk("irq_one_left", irq_req, 1'b1);
    src = 2'h0;
    wt(4);
    chk("irq_after_release", irq_req, edge_mode);
    ack = 1;
    wt(1);
    ack = 0;
    wt(2);
    chk("irq_after_ack", irq_req, 1'b0);
    esel = 0;
  endtask
  task automatic t_async_reset;
    // An edge latched before reset must not survive it
    esel = 1;
    src = 2'h1;
    wt(4);
    chk("irq_edge_pre", irq_req, 1'h1);
    i_rst_n = 0;
    wt(2);
    chk("sys_rst_n_por", srst_n, 1'h0);
    chk("irq_por", irq_req, 1'h0);
    chk("eclk_por", eclk, 1'h0);
    src = 2'h0;
    i_rst_n = 1;
    wt(8);
    chk("sys_rst_n_por_up", srst_n, 1'h1);
    chk("irq_por_cleared", irq_req, 1'h0);
    chk("reset_external_por", rext, 1'h0);
  endtask
  initial begin
    wt(12);
    chk("sys_rst_n_in_reset", srst_n, 1'b0);
    chk("eclk_in_reset", eclk, 1'b0);
    i_rst_n = 1;
    wt(30);
    t_divider();
    t_halt_gate();
    t_irq(1'b0);
    t_irq(1'b1);
    t_async_reset();
    esel = 1;
    t_reset(1'b1, 1'b0);
    t_reset(1'b0, 1'b1);
    t_irq(1'b0);
    t_divider();
    end_sim();
  end
endmodule // crp_clock_reset_irq_tb
`default_nettype wire
